// ### verilog/cfb_feedback_config.sv
// Closed-loop feedback configuration bank with Wishbone register access
//
// Overview of operation
// - Feedback gain derives from the 8-bit back-EMF scale, reset 109.
// - Drive below the noise-gate threshold is replaced by zero output.
// - Control bit 7 picks 4% or 8% of supply; resets to 0.
// - Bits 6:4 pick brake ratio 1,2,3,4,6,8,16; resets to code 3.
// - Brake code 7 removes feedback during braking, disabling braking.
// - Bits 3:2 select loop gain (settling speed); resets to 1.
// - Bits 1:0 set sense amplifier gain code; resets to 2.
// - Calibration writes amp gain; later software writes override it.
//
// Decided for this implementation: the Wishbone register port.
`default_nettype none
`include "cfb_defines.svh"

module cfb_feedback_config #(
    parameter int DW = 12,
    parameter int GW = 16
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          sys_rst,
    // Wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // Playback engine side
    input  wire logic [DW-1:0] driveLevel,
    input  wire logic [DW-1:0] supplyLevel,
    input  wire logic          braking,
    input  wire logic          calAmpValid,
    input  wire logic [1:0]    calAmpCode,
    // Derived controls
    output logic      [GW-1:0] feedbackGain,
    output logic               brakeFeedbackOn,
    output logic      [DW-1:0] gatedLevel,
    output logic               gateActive,
    output logic      [1:0]    loopGainSel,
    output logic      [1:0]    senseAmpGain
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0]  backemfScaleCal;
    logic [7:0]  feedbackLoopControl;
    logic        ack;
    logic [31:0] datOut;
    logic [7:0]  next_backemfScaleCal;
    logic [7:0]  next_feedbackLoopControl;
    logic        next_ack;
    logic [31:0] next_datOut;
    logic [5:0]  regIdx;
    logic        access;
    logic        swWrite;
    logic        swScaleWrite;
    logic        swCtrlWrite;

    cfb_pkg::cfb_brake_e brakeCode;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    always_comb begin
        regIdx       = wb_adr_i[7:2];
        access       = wb_cyc_i && wb_stb_i;
        swWrite      = access && wb_we_i && ack && wb_sel_i[0];
        swScaleWrite = swWrite && regIdx == `CFB_IDX_SCALE;
        swCtrlWrite  = swWrite && regIdx == `CFB_IDX_CTRL;
    end

    // ****************************************************************
    // Next register values
    // ****************************************************************
    always_comb begin
        next_backemfScaleCal     = backemfScaleCal;
        next_feedbackLoopControl = feedbackLoopControl;
        next_ack                 = access && !ack;
        next_datOut              = datOut;
        if (swScaleWrite) begin
            next_backemfScaleCal = wb_dat_i[7:0];
        end
        if (calAmpValid) begin
            next_feedbackLoopControl[`CFB_AMP_HI:`CFB_AMP_LO] =
                calAmpCode;
        end
        if (swCtrlWrite) begin
            next_feedbackLoopControl = wb_dat_i[7:0];
        end
        if (access && !ack) begin
            if (wb_we_i) begin
                next_datOut = 32'h0000_0000;
            end else if (regIdx == `CFB_IDX_SCALE) begin
                next_datOut = {24'h00_0000, backemfScaleCal};
            end else if (regIdx == `CFB_IDX_CTRL) begin
                next_datOut = {24'h00_0000, feedbackLoopControl};
            end else begin
                next_datOut = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            backemfScaleCal     <= `CFB_SCALE_RST;
            feedbackLoopControl <= `CFB_CTRL_RST;
            ack                 <= 1'b0;
            datOut              <= 32'h0000_0000;
        end else begin
            backemfScaleCal     <= next_backemfScaleCal;
            feedbackLoopControl <= next_feedbackLoopControl;
            ack                 <= next_ack;
            datOut              <= next_datOut;
        end
    end

    // ****************************************************************
    // Field outputs
    // ****************************************************************
    always_comb begin
        wb_ack_o     = ack;
        wb_dat_o     = datOut;
        brakeCode    = cfb_pkg::cfb_brake_e'(
            feedbackLoopControl[`CFB_BRK_HI:`CFB_BRK_LO]);
        loopGainSel  = feedbackLoopControl[`CFB_LOOP_HI:`CFB_LOOP_LO];
        senseAmpGain =
            feedbackLoopControl[`CFB_AMP_HI:`CFB_AMP_LO];
    end

    // ****************************************************************
    // Gain and gate engines
    // ****************************************************************
    cfb_gain_calc #(
        .GW              (GW)
    ) u_gain (
        .core_clk        (core_clk),
        .sys_rst         (sys_rst),
        .scale           (backemfScaleCal),
        .loopGain        (loopGainSel),
        .brakeCode       (brakeCode),
        .braking         (braking),
        .feedbackGain    (feedbackGain),
        .brakeFeedbackOn (brakeFeedbackOn)
    );

    cfb_noise_gate #(
        .W               (DW)
    ) u_gate (
        .core_clk        (core_clk),
        .sys_rst         (sys_rst),
        .driveLevel      (driveLevel),
        .supplyLevel     (supplyLevel),
        .gateHigh        (feedbackLoopControl[`CFB_NG_BIT]),
        .gatedLevel      (gatedLevel),
        .gateActive      (gateActive)
    );

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    logic [GW-1:0] expBase;
    logic [GW-1:0] expBrake;
    logic [DW+6:0] chkDrive;
    logic [DW+6:0] chkLimit;
    logic          chkBelow;

    always_comb begin
        expBase  = GW'(backemfScaleCal)
            * GW'({1'b0, loopGainSel} + 3'h1);
        expBrake = GW'(expBase * GW'(cfb_pkg::cfb_brake_ratio(brakeCode)));
        chkDrive = (DW+7)'(driveLevel) * (DW+7)'(`CFB_PCT_FULL);
        chkLimit = (DW+7)'(supplyLevel) * (DW+7)'(
            feedbackLoopControl[`CFB_NG_BIT]
                ? `CFB_NG_HIGH_PCT : `CFB_NG_LOW_PCT);
        chkBelow = chkDrive < chkLimit;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    scale_write_a: assert property (
        swScaleWrite |=> backemfScaleCal == $past(wb_dat_i[7:0]))
        else $error("scale register missed a write");

    drive_gain_a: assert property (
        !sys_rst && !braking |=> feedbackGain == $past(expBase))
        else $error("drive gain not scale times loop gain");

    brake_gain_a: assert property (
        !sys_rst && braking && brakeCode != cfb_pkg::CFB_BRK_OFF
            |=> feedbackGain == $past(expBrake))
        else $error("brake gain not scaled by ratio");

    brake_off_a: assert property (
        !sys_rst && braking && brakeCode == cfb_pkg::CFB_BRK_OFF
            |=> feedbackGain == '0 && !brakeFeedbackOn)
        else $error("braking feedback not removed for code 7");

    gate_zero_a: assert property (
        !sys_rst && chkBelow |=> gatedLevel == '0 && gateActive)
        else $error("drive below threshold not gated");

    gate_pass_a: assert property (
        !sys_rst && !chkBelow
            |=> gatedLevel == $past(driveLevel) && !gateActive)
        else $error("drive above threshold altered");

    loop_field_a: assert property (
        swCtrlWrite |=> loopGainSel == $past(wb_dat_i[3:2])
            && brakeCode == cfb_pkg::cfb_brake_e'($past(wb_dat_i[6:4])))
        else $error("control fields missed a write");

    cal_amp_a: assert property (
        calAmpValid && !swCtrlWrite
            |=> senseAmpGain == $past(calAmpCode)
            && loopGainSel == $past(loopGainSel))
        else $error("calibration gain not captured alone");

    sw_over_a: assert property (
        swCtrlWrite |=> senseAmpGain == $past(wb_dat_i[1:0]))
        else $error("software gain write did not override");

    ack_pulse_a: assert property (
        access && !ack |=> ack ##1 !ack)
        else $error("ack not a one cycle answer");

    read_back_a: assert property (
        access && !wb_we_i && !ack && regIdx == `CFB_IDX_SCALE
            |=> wb_dat_o == {24'h00_0000, $past(backemfScaleCal)})
        else $error("scale read back wrong");

    brake_on_a: assert property (
        brakeCode != cfb_pkg::CFB_BRK_OFF |=> brakeFeedbackOn)
        else $error("braking feedback dropped for a live code");

    // ****************************************************************
    // Register bus checks
    // ****************************************************************
    ctrl_write_a: assert property (
        swCtrlWrite |=> feedbackLoopControl == $past(wb_dat_i[7:0]))
        else $error("control register missed a write");

    scale_hold_a: assert property (
        !swScaleWrite |=> backemfScaleCal == $past(backemfScaleCal))
        else $error("scale register changed without a write");

    ctrl_hold_a: assert property (
        !swCtrlWrite && !calAmpValid
            |=> feedbackLoopControl == $past(feedbackLoopControl))
        else $error("control register changed without a write");

    sel_skip_a: assert property (
        access && wb_we_i && ack && !wb_sel_i[0] && !calAmpValid
            |=> feedbackLoopControl == $past(feedbackLoopControl)
            && backemfScaleCal == $past(backemfScaleCal))
        else $error("write without low byte lane took effect");

    ack_idle_a: assert property (
        !access |=> !ack)
        else $error("ack without a request");

    dat_hold_a: assert property (
        !(access && !ack) |=> wb_dat_o == $past(wb_dat_o))
        else $error("read data changed outside a request");

    ctrl_read_a: assert property (
        access && !wb_we_i && !ack && regIdx == `CFB_IDX_CTRL
            |=> wb_dat_o == {24'h00_0000, $past(feedbackLoopControl)})
        else $error("control read back wrong");

    unmapped_read_a: assert property (
        access && !ack && regIdx != `CFB_IDX_SCALE
            && regIdx != `CFB_IDX_CTRL |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped access returned data");

    // ****************************************************************
    // Reset checks
    // ****************************************************************
    reg_reset_a: assert property (
        disable iff (1'b0)
        sys_rst |=> backemfScaleCal == `CFB_SCALE_RST
            && feedbackLoopControl == `CFB_CTRL_RST)
        else $error("register reset values wrong");

    out_reset_a: assert property (
        disable iff (1'b0)
        sys_rst |=> !ack && datOut == 32'h0000_0000
            && feedbackGain == '0 && brakeFeedbackOn
            && gatedLevel == '0 && !gateActive)
        else $error("outputs not cleared by reset");

endmodule

`default_nettype wire

// ### verilog/cfb_defines.svh
// Offsets, field positions and reset values of the feedback config bank
`ifndef CFB_DEFINES_SVH
`define CFB_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define CFB_IDX_SCALE     6'h22
`define CFB_IDX_CTRL      6'h23

// ****************************************************************
// Reset values
// ****************************************************************
`define CFB_SCALE_RST     8'h6D
`define CFB_CTRL_RST      8'h36

// ****************************************************************
// Control register fields
// ****************************************************************
`define CFB_NG_BIT        7
`define CFB_BRK_HI        6
`define CFB_BRK_LO        4
`define CFB_LOOP_HI       3
`define CFB_LOOP_LO       2
`define CFB_AMP_HI        1
`define CFB_AMP_LO        0

// ****************************************************************
// Noise gate thresholds in percent of supply
// ****************************************************************
`define CFB_NG_LOW_PCT    7'h04
`define CFB_NG_HIGH_PCT   7'h08
`define CFB_PCT_FULL      7'h64

`endif

// ### verilog/cfb_pkg.sv
// Types and the brake ratio table of the feedback config bank
`default_nettype none

package cfb_pkg;

    // Brake ratio codes
    typedef enum logic [2:0] {
        CFB_BRK_X1   = 3'h0,
        CFB_BRK_X2   = 3'h1,
        CFB_BRK_X3   = 3'h2,
        CFB_BRK_X4   = 3'h3,
        CFB_BRK_X6   = 3'h4,
        CFB_BRK_X8   = 3'h5,
        CFB_BRK_X16  = 3'h6,
        CFB_BRK_OFF  = 3'h7
    } cfb_brake_e;

    typedef logic [4:0] cfb_ratio_t;

    // Brake to drive gain ratio; zero when braking feedback is removed
    function automatic cfb_ratio_t cfb_brake_ratio(input cfb_brake_e code);
        cfb_ratio_t r;
        r = 5'h00;
        unique case (code)
            CFB_BRK_X1:  r = 5'h01;
            CFB_BRK_X2:  r = 5'h02;
            CFB_BRK_X3:  r = 5'h03;
            CFB_BRK_X4:  r = 5'h04;
            CFB_BRK_X6:  r = 5'h06;
            CFB_BRK_X8:  r = 5'h08;
            CFB_BRK_X16: r = 5'h10;
            CFB_BRK_OFF: r = 5'h00;
        endcase
        return r;
    endfunction

endpackage

`default_nettype wire

// ### verilog/cfb_noise_gate.sv
// Output noise gate that zeroes drive levels below a supply fraction
`default_nettype none
`include "cfb_defines.svh"

module cfb_noise_gate #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // Drive request
    input  wire logic [W-1:0] driveLevel,
    input  wire logic [W-1:0] supplyLevel,
    input  wire logic         gateHigh,
    // Gated drive
    output logic      [W-1:0] gatedLevel,
    output logic              gateActive
);

    logic [W+6:0] scaledDrive;
    logic [W+6:0] scaledLimit;
    logic [6:0]   pct;
    logic         below;
    logic [W-1:0] next_gatedLevel;
    logic         next_gateActive;

    // ****************************************************************
    // Threshold compare
    // ****************************************************************
    always_comb begin
        pct             = gateHigh ? `CFB_NG_HIGH_PCT : `CFB_NG_LOW_PCT;
        scaledDrive     = (W+7)'(driveLevel) * (W+7)'(`CFB_PCT_FULL);
        scaledLimit     = (W+7)'(supplyLevel) * (W+7)'(pct);
        below           = scaledDrive < scaledLimit;
        next_gatedLevel = below ? '0 : driveLevel;
        next_gateActive = below;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gatedLevel <= '0;
            gateActive <= 1'b0;
        end else begin
            gatedLevel <= next_gatedLevel;
            gateActive <= next_gateActive;
        end
    end

endmodule

`default_nettype wire

// ### verilog/cfb_gain_calc.sv
// Feedback gain from back-EMF scale, loop gain and brake ratio
`default_nettype none

module cfb_gain_calc #(
    parameter int GW = 16
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // Settings
    input  wire logic [7:0]        scale,
    input  wire logic [1:0]        loopGain,
    input  wire cfb_pkg::cfb_brake_e brakeCode,
    input  wire logic              braking,
    // Gain out
    output logic      [GW-1:0]     feedbackGain,
    output logic                   brakeFeedbackOn
);

    logic [GW-1:0] baseGain;
    logic [GW-1:0] next_feedbackGain;
    logic          next_brakeFeedbackOn;

    always_comb begin
        baseGain = GW'(scale) * GW'({1'b0, loopGain} + 3'h1);
        next_brakeFeedbackOn = brakeCode != cfb_pkg::CFB_BRK_OFF;
        if (braking) begin
            // Code 7 yields ratio zero, removing braking feedback
            next_feedbackGain = GW'(baseGain
                * GW'(cfb_pkg::cfb_brake_ratio(brakeCode)));
        end else begin
            next_feedbackGain = baseGain;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            feedbackGain    <= '0;
            brakeFeedbackOn <= 1'b1;
        end else begin
            feedbackGain    <= next_feedbackGain;
            brakeFeedbackOn <= next_brakeFeedbackOn;
        end
    end

endmodule

`default_nettype wire

// ### sim/test_closed_loop_feedback_config.sv
// Self-checking bench of the closed-loop feedback config bank
`default_nettype none
`include "cfb_defines.svh"

module test_closed_loop_feedback_config;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         DW        = 12;
    localparam int         GW        = 16;
    localparam logic [7:0] ADR_SCALE = {`CFB_IDX_SCALE, 2'h0};
    localparam logic [7:0] ADR_CTRL  = {`CFB_IDX_CTRL, 2'h0};
    localparam int         RATIO [8] = '{1, 2, 3, 4, 6, 8, 16, 0};

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic          core_clk;
    logic          sys_rst;
    logic          wb_cyc_i;
    logic          wb_stb_i;
    logic          wb_we_i;
    logic [7:0]    wb_adr_i;
    logic [3:0]    wb_sel_i;
    logic [31:0]   wb_dat_i;
    logic [31:0]   wb_dat_o;
    logic          wb_ack_o;
    logic [DW-1:0] driveLevel;
    logic [DW-1:0] supplyLevel;
    logic          braking;
    logic          calAmpValid;
    logic [1:0]    calAmpCode;
    logic [GW-1:0] feedbackGain;
    logic          brakeFeedbackOn;
    logic [DW-1:0] gatedLevel;
    logic          gateActive;
    logic [1:0]    loopGainSel;
    logic [1:0]    senseAmpGain;
    int            badCount;
    int            nTests;

    cfb_feedback_config #(.DW(DW), .GW(GW)) u_dut (
        .core_clk        (core_clk),
        .sys_rst         (sys_rst),
        .wb_cyc_i        (wb_cyc_i),
        .wb_stb_i        (wb_stb_i),
        .wb_we_i         (wb_we_i),
        .wb_adr_i        (wb_adr_i),
        .wb_sel_i        (wb_sel_i),
        .wb_dat_i        (wb_dat_i),
        .wb_dat_o        (wb_dat_o),
        .wb_ack_o        (wb_ack_o),
        .driveLevel      (driveLevel),
        .supplyLevel     (supplyLevel),
        .braking         (braking),
        .calAmpValid     (calAmpValid),
        .calAmpCode      (calAmpCode),
        .feedbackGain    (feedbackGain),
        .brakeFeedbackOn (brakeFeedbackOn),
        .gatedLevel      (gatedLevel),
        .gateActive      (gateActive),
        .loopGainSel     (loopGainSel),
        .senseAmpGain    (senseAmpGain)
    );

    always #4 core_clk = ~core_clk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic stopTest();
        $display("Checks made: %0d, mismatches: %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wbCycle(input logic we, input logic [7:0] adr,
                           input logic [3:0] sel, input logic [7:0] dat,
                           output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, dat};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            badCount++;
            stopTest();
        end
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wrReg(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        wbCycle(1'b1, adr, 4'hF, dat, d);
    endtask

    task automatic rdReg(input logic [7:0] adr, output logic [31:0] d);
        wbCycle(1'b0, adr, 4'hF, 8'h00, d);
    endtask

    task automatic doReset();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic checkDefaults();
        logic [31:0] d;
        rdReg(ADR_SCALE, d);
        check(d, 32'h0000006D);
        rdReg(ADR_CTRL, d);
        check(d, 32'h00000036);
        check(32'(loopGainSel), 32'h1);
        check(32'(senseAmpGain), 32'h2);
        check(32'(brakeFeedbackOn), 32'h1);
        check(32'(feedbackGain), 32'(109 * 2));
    endtask

    task automatic testRegs();
        logic [31:0] d;
        wrReg(ADR_SCALE, 8'hA5);
        wbCycle(1'b1, ADR_SCALE, 4'hE, 8'h5A, d);
        rdReg(ADR_SCALE, d);
        check(d, 32'h000000A5);
        wrReg(8'h90, 8'hFF);
        rdReg(8'h90, d);
        check(d, 32'h00000000);
        wrReg(ADR_CTRL, 8'hC9);
        rdReg(ADR_CTRL, d);
        check(d, 32'h000000C9);
        check(32'(loopGainSel), 32'h2);
        check(32'(senseAmpGain), 32'h1);
    endtask

    task automatic testCal();
        logic [31:0] d;
        wrReg(ADR_CTRL, 8'h2A);
        @(posedge core_clk);
        calAmpCode  <= 2'h1;
        calAmpValid <= 1'b1;
        @(posedge core_clk);
        calAmpValid <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(32'(senseAmpGain), 32'h1);
        check(32'(loopGainSel), 32'h2);
        rdReg(ADR_CTRL, d);
        check(d, 32'h00000029);
        wrReg(ADR_CTRL, 8'h37);
        rdReg(ADR_CTRL, d);
        check(d, 32'h00000037);
        check(32'(senseAmpGain), 32'h3);
    endtask

    task automatic testBrake();
        logic [GW-1:0] base;
        base = GW'(8'h33 * 3);
        wrReg(ADR_SCALE, 8'h33);
        for (int c = 0; c < 8; c++) begin
            wrReg(ADR_CTRL, {1'b0, 3'(c), 2'h2, 2'h1});
            braking <= 1'b1;
            repeat (3) @(posedge core_clk);
            check(32'(feedbackGain), 32'(base * RATIO[c]));
            check(32'(brakeFeedbackOn), 32'(c != 7));
            braking <= 1'b0;
            repeat (3) @(posedge core_clk);
            check(32'(feedbackGain), 32'(base));
            check(32'(loopGainSel), 32'h2);
        end
    endtask

    task automatic testGate();
        logic [DW-1:0] lvl;
        supplyLevel <= 12'h3E8;
        for (int i = 0; i < 4; i++) begin
            lvl = DW'((i >= 2) ? 80 : 40) - DW'(i % 2 == 0);
            wrReg(ADR_CTRL, {1'(i >= 2), 3'h3, 2'h1, 2'h2});
            driveLevel <= lvl;
            repeat (3) @(posedge core_clk);
            check(32'(gateActive), 32'(i % 2 == 0));
            check(32'(gatedLevel), (i % 2) ? 32'(lvl) : 32'h0);
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        core_clk    = 1'b0;
        sys_rst     = 1'b1;
        wb_cyc_i    = 1'b0;
        wb_stb_i    = 1'b0;
        wb_we_i     = 1'b0;
        wb_adr_i    = 8'h00;
        wb_sel_i    = 4'h0;
        wb_dat_i    = 32'h00000000;
        driveLevel  = 12'h000;
        supplyLevel = 12'h000;
        braking     = 1'b0;
        calAmpValid = 1'b0;
        calAmpCode  = 2'h0;
        badCount    = 0;
        nTests      = 0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        checkDefaults();
        testRegs();
        doReset();
        checkDefaults();
        testCal();
        testBrake();
        testGate();
        stopTest();
    end
endmodule

`default_nettype wire
